//--- bench/afsh_aux_strobe_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches the strobe, completion and waiting handshakes at the top ports
module afsh_aux_strobe_chk (
  input wire logic sys_clk, rst_n, blkValid, blkReady, auxLock, cfgHighSpeed, finConv,
  input wire logic ownWaitValid, peerWaitValid, waitIgnore,
  input wire logic [afsh_pkg::NCHAN-1:0] finHs, auxStrobe,
  input wire logic [afsh_pkg::CODE_W-1:0] ownWaitCode, peerWaitCode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic take = blkValid && blkReady;
  wire logic conv = !cfgHighSpeed;
  a_lock_quiet:
    assert property (take && auxLock |=> $stable(auxStrobe)) else $error("strobe under lock");
  a_conv_busy:
    assert property (conv && |auxStrobe |-> !blkReady) else $error("ready while strobe high");
  a_conv_early:
    assert property (conv && auxStrobe[0] && finConv |=> auxStrobe[0]) else $error("early done");
  a_conv_done:
    assert property (conv && auxStrobe[0] && $fell(finConv) |=> !auxStrobe[0])
      else $error("no done on fall");
  a_hs_once:
    assert property (cfgHighSpeed && $changed(auxStrobe) |=> $stable(auxStrobe))
      else $error("second toggle");
  a_hs_done:
    assert property (cfgHighSpeed && finHs == auxStrobe && !ownWaitValid && !take |=> blkReady)
      else $error("no done on equal level");
  a_wait_hold:
    assert property (ownWaitValid && !waitIgnore && !peerWaitValid |=> ownWaitValid)
      else $error("wait left early");
  a_wait_free:
    assert property (ownWaitValid && (waitIgnore || peerWaitValid && peerWaitCode == ownWaitCode)
      |=> !ownWaitValid) else $error("wait stuck");
  a_wait_silent:
    assert property ($rose(ownWaitValid) |-> $stable(auxStrobe) && !blkReady)
      else $error("wait code output");
  c_lock: cover property (take && auxLock);
  c_wait: cover property ($rose(ownWaitValid));
  c_hs: cover property (cfgHighSpeed && $changed(auxStrobe));
endmodule : afsh_aux_strobe_chk
bind afsh_aux_strobe afsh_aux_strobe_chk chk (.*);
`default_nettype wire

//--- bench/afsh_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// machine side sequence controller: answers each strobe after dly cycles
module afsh_seq_model (
  input wire logic sys_clk, cfgHighSpeed,
  input wire logic [afsh_pkg::NCHAN-1:0] auxStrobe,
  input wire logic [2:0] dly,
  output logic finConv,
  output logic [afsh_pkg::NCHAN-1:0] finHs
);
  initial begin
    finConv = 1'b0;
    finHs = '0;
    forever begin
      @(posedge sys_clk);
      #1;
      if (cfgHighSpeed && finHs !== auxStrobe) begin // one line per function
        repeat (dly) @(posedge sys_clk);
        #1 finHs = auxStrobe; // copy strobe level
      end else if (!cfgHighSpeed && |auxStrobe) begin // shared line
        repeat (dly) @(posedge sys_clk);
        #1 finConv = 1'b1; // rise, then fall
        repeat (dly + 1) @(posedge sys_clk);
        #1 finConv = 1'b0;
      end
    end
  end
endmodule : afsh_seq_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import afsh_pkg::*;
  typedef struct packed {logic [2:0] ch; logic [CODE_W-1:0] code;} afsh_res_type;
  logic sys_clk, rst_n, blkValid, blkReady, blkSValid, blkTValid, cfgHighSpeed, cfgMultiM;
  logic auxLock, waitIgnore, finConv, ownWaitValid, peerWaitValid, prevW;
  logic [1:0] blkMCount, blkBCount;
  logic [3:0] cfgMDigits;
  logic [2:0] dly;
  wire logic [8:0] pulses;
  logic [8:0] fixPulse [13], pulseQ [$];
  logic [NCHAN-1:0] finHs, auxStrobe, prevS;
  logic [MAX_M-1:0][CODE_W-1:0] blkMCode;
  logic [NCHAN-1:0][CODE_W-1:0] auxCodeLines;
  logic [CODE_W-1:0] blkSCode, blkTCode, blkBCode, ownWaitCode, peerWaitCode, m0, m1;
  logic [CODE_W-1:0] cfgCode [6], fixCode [13];
  afsh_letter_type blkBLetter, cfgBLetter;
  afsh_res_type codeQ [$];
  int mismatches, checkCount, seed, n;
  afsh_aux_strobe uut (.sys_clk, .rst_n, .blkValid, .blkReady, .blkMCount, .blkMCode,
    .blkSValid, .blkSCode, .blkTValid, .blkTCode, .blkBCount, .blkBLetter, .blkBCode,
    .cfgHighSpeed, .cfgMultiM, .cfgMDigits, .cfgBDigits(cfgMDigits), .cfgBLetter,
    .cfgSubCallCode(cfgCode[0]), .cfgMacroCallCode(cfgCode[1]), .cfgIntrOnCode(cfgCode[2]),
    .cfgIntrOffCode(cfgCode[3]), .cfgWaitLow(cfgCode[4]), .cfgWaitHigh(cfgCode[5]),
    .auxLock, .waitIgnore, .finConv, .finHs, .auxCodeLines, .auxStrobe, .ownWaitValid,
    .ownWaitCode, .peerWaitValid, .peerWaitCode, .progEnd(pulses[8]), .progStop(pulses[7]),
    .optStop(pulses[6]), .subCall(pulses[5]), .subReturn(pulses[4]), .macroCall(pulses[3]),
    .intrMacroOn(pulses[2]), .intrMacroOff(pulses[1]), .blkAlarm(pulses[0]));
  afsh_seq_model seq (.sys_clk, .cfgHighSpeed, .auxStrobe, .dly, .finConv, .finHs);
  task automatic results;
    mismatches += codeQ.size() + pulseQ.size();
    $display("mismatches %0d comparisons %0d", mismatches, checkCount);
    if (mismatches == 0 && checkCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic bad(input string s);
    mismatches++;
    $display("wrong value at %0t: %s", $time, s);
  endtask : bad
  task automatic compare_code(input afsh_res_type got);
    checkCount++;
    if (got !== codeQ.pop_front()) bad($sformatf("ch %0d code %h", got.ch, got.code));
  endtask : compare_code
  task automatic compare_pulse(input logic [8:0] got);
    checkCount++;
    if (got !== pulseQ.pop_front()) bad($sformatf("pulses %h", got));
  endtask : compare_pulse
  task automatic ec(input int ch, input logic [CODE_W-1:0] c);
    codeQ.push_back({3'(ch), c});
  endtask : ec
  // offer one block at a falling edge once ready
  task automatic blk(input logic [1:0] mc, input logic [CODE_W-1:0] a, b, input logic [1:0] bc);
    for (n = 0; n < 300 && blkReady !== 1'b1; n++) @(negedge sys_clk);
    if (n == 300) begin
      bad("ready never came");
      results();
    end
    {blkMCount, blkBCount, blkMCode, blkValid} = {mc, bc, b, b, a, 1'b1};
    @(negedge sys_clk);
    blkValid = 1'b0;
    @(negedge sys_clk);
  endtask : blk
  // result watcher: oldest note against each strobe, wait or pulse
  always @(negedge sys_clk) begin
    if (rst_n) begin
      for (int i = 0; i < NCHAN; i++)
        if (auxStrobe[i] !== prevS[i] && (cfgHighSpeed || auxStrobe[i]))
          compare_code({3'(i), auxCodeLines[i]});
      if (ownWaitValid === 1'b1 && prevW === 1'b0) compare_code({3'h6, ownWaitCode});
      if (pulses !== '0) compare_pulse(pulses);
    end
    prevS = auxStrobe;
    prevW = ownWaitValid;
  end
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    seed = 56141;
    {rst_n, blkValid, blkSValid, blkTValid, cfgHighSpeed, cfgMultiM, auxLock, waitIgnore} = '0;
    {peerWaitValid, blkMCount, blkBCount, blkMCode, peerWaitCode} = '0;
    {blkSCode, blkTCode, mismatches, checkCount, dly, cfgMDigits} = {64'h0, 64'h0, 7'h58};
    blkBLetter = AFSH_LET_B;
    cfgBLetter = AFSH_LET_B;
    blkBCode = 32'h00BC_614E;
    cfgCode = '{32'h0000_0384, 32'h0000_0385, 32'h0000_0386, 32'h0000_0387, 32'h0000_01F4,
      32'h0000_0257};
    fixCode = '{M_END, M_END_RW, M_STOP, M_OPT_STOP, M_SUB_CALL, M_SUB_RET, M_EXT_CALL,
      cfgCode[0], cfgCode[1], M_INTR_ON, M_INTR_OFF, cfgCode[2], cfgCode[3]};
    fixPulse = '{9'h100, 9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h020, 9'h020, 9'h008,
      9'h004, 9'h002, 9'h004, 9'h002};
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    ec(0, 32'h0000_0028);
    blk(1, 32'h0000_0028, 0, 0);
    pulseQ.push_back(9'h001);
    blk(2, 32'h0000_0028, 32'h0000_0032, 0);
    cfgMDigits = 4'h2;
    pulseQ.push_back(9'h001);
    blk(1, 32'h0000_0064, 0, 0);
    cfgMDigits = 4'h8;
    // special and internal codes, then the first nine again under lock
    for (int k = 0; k < 2; k++)
      for (int i = 0; i < (k ? 9 : 13); i++) begin
        auxLock = k[0];
        if (!k && i < 4) ec(0, fixCode[i]);
        pulseQ.push_back(fixPulse[i]);
        blk(1, fixCode[i], 0, 0);
      end
    blk(1, 32'h0000_0028, 0, 0);
    {auxLock, cfgMultiM, blkSValid} = 3'h3;
    for (int i = 0; i < 2; i++) begin
      dly = i ? 3'h6 : 3'h0;
      m0 = 32'h0000_00C8 + 32'($unsigned($random(seed)) % 300);
      m1 = 32'h0000_00C8 + 32'($unsigned($random(seed)) % 300);
      blkSCode = 32'($unsigned($random(seed)) % 32'h000F_4240);
      ec(0, m0); ec(1, m1); ec(2, m1); ec(3, blkSCode);
      blk(3, m0, m1, 0);
    end
    blkSValid = 1'b0;
    ec(5, blkBCode);
    blk(0, 0, 0, 1);
    pulseQ.push_back(9'h001);
    blk(0, 0, 0, 2);
    cfgBLetter = AFSH_LET_W;
    pulseQ.push_back(9'h001);
    blk(0, 0, 0, 1);
    blkBLetter = AFSH_LET_W;
    blkBCode = 32'h05F5_E0FF;
    ec(5, blkBCode);
    blk(0, 0, 0, 1);
    ec(6, 32'h0000_0226);
    blk(1, 32'h0000_0226, 0, 0);
    repeat (6) @(negedge sys_clk);
    {peerWaitValid, peerWaitCode} = {1'b1, 32'h0000_0226};
    @(negedge sys_clk);
    peerWaitValid = 1'b0;
    ec(6, 32'h0000_0226);
    blk(1, 32'h0000_0226, 0, 0);
    repeat (3) @(negedge sys_clk);
    waitIgnore = 1'b1;
    @(negedge sys_clk);
    {waitIgnore, cfgHighSpeed, blkTValid} = 3'h3;
    for (int i = 0; i < 3; i++) begin
      dly = 3'(i);
      blkTCode = 32'($unsigned($random(seed)) % 1000);
      ec(0, 32'h0000_0028); ec(4, blkTCode);
      blk(1, 32'h0000_0028, 0, 0);
    end
    for (n = 0; n < 300 && codeQ.size() + pulseQ.size() > 0; n++) @(negedge sys_clk);
    ec(5, 32'h05F5_E0FF);
    compare_code({3'h5, auxCodeLines[5]});
    results();
  end
endmodule : tb
`default_nettype wire

//--- rtl/afsh_aux_strobe.sv
`timescale 1ns/1ps
`default_nettype none

module afsh_aux_strobe (
  // clock and reset
  input  wire logic                                         sys_clk,
  input  wire logic                                         rst_n,
  // decoded block from the interpreter
  input  wire logic                                         blkValid,
  output logic                                              blkReady,
  input  wire logic [1:0]                                   blkMCount,
  input  wire logic [afsh_pkg::MAX_M-1:0][afsh_pkg::CODE_W-1:0] blkMCode,
  input  wire logic                                         blkSValid,
  input  wire logic [afsh_pkg::CODE_W-1:0]                  blkSCode,
  input  wire logic                                         blkTValid,
  input  wire logic [afsh_pkg::CODE_W-1:0]                  blkTCode,
  input  wire logic [1:0]                                   blkBCount,
  input  wire afsh_pkg::afsh_letter_type                    blkBLetter,
  input  wire logic [afsh_pkg::CODE_W-1:0]                  blkBCode,
  // configuration
  input  wire logic                                         cfgHighSpeed,
  input  wire logic                                         cfgMultiM,
  input  wire logic [3:0]                                   cfgMDigits,
  input  wire logic [3:0]                                   cfgBDigits,
  input  wire afsh_pkg::afsh_letter_type                    cfgBLetter,
  input  wire logic [afsh_pkg::CODE_W-1:0]                  cfgSubCallCode,
  input  wire logic [afsh_pkg::CODE_W-1:0]                  cfgMacroCallCode,
  input  wire logic [afsh_pkg::CODE_W-1:0]                  cfgIntrOnCode,
  input  wire logic [afsh_pkg::CODE_W-1:0]                  cfgIntrOffCode,
  input  wire logic [afsh_pkg::CODE_W-1:0]                  cfgWaitLow,
  input  wire logic [afsh_pkg::CODE_W-1:0]                  cfgWaitHigh,
  // machine side control inputs
  input  wire logic                                         auxLock,
  input  wire logic                                         waitIgnore,
  input  wire logic                                         finConv,
  input  wire logic [afsh_pkg::NCHAN-1:0]                   finHs,
  // code lines and strobes toward the sequence controller
  output logic      [afsh_pkg::NCHAN-1:0][afsh_pkg::CODE_W-1:0] auxCodeLines,
  output logic      [afsh_pkg::NCHAN-1:0]                   auxStrobe,
  // waiting handshake with the other path
  output logic                                              ownWaitValid,
  output logic      [afsh_pkg::CODE_W-1:0]                  ownWaitCode,
  input  wire logic                                         peerWaitValid,
  input  wire logic [afsh_pkg::CODE_W-1:0]                  peerWaitCode,
  // internal effects, one cycle pulses
  output logic                                              progEnd,
  output logic                                              progStop,
  output logic                                              optStop,
  output logic                                              subCall,
  output logic                                              subReturn,
  output logic                                              macroCall,
  output logic                                              intrMacroOn,
  output logic                                              intrMacroOff,
  output logic                                              blkAlarm
);
  import afsh_pkg::*;

  // ***********************************************************
  // state
  // ***********************************************************
  // one-hot states
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,   // taking blocks
    ST_SYNC = 2'b10    // holding at a waiting code
  } afsh_state_type;

  // whole state
  typedef struct packed {
    afsh_state_type    state;     // sequencing state
    logic              waitValid; // own waiting code shown
    logic [CODE_W-1:0] waitCode;  // own waiting code
    logic              progEnd;   // end of program pulse
    logic              progStop;  // program stop pulse
    logic              optStop;   // optional stop pulse
    logic              subCall;   // subprogram call pulse
    logic              subRet;    // subprogram return pulse
    logic              macCall;   // macro call pulse
    logic              intrOn;    // interrupt macro on pulse
    logic              intrOff;   // interrupt macro off pulse
    logic              alarm;     // block refused pulse
  } afsh_main_type;

  afsh_main_type st_reg;   // registered state
  afsh_main_type st_next;  // next state

  // helper signals
  logic [NCHAN-1:0]             chanBusy;   // channel waiting for completion
  logic [NCHAN-1:0]             chanStart;  // start pulse per channel
  logic [NCHAN-1:0][CODE_W-1:0] chanCode;   // code per channel
  logic                         take;       // block accepted this cycle
  logic                         bad;        // block is refused
  logic [MAX_M-1:0]             mUsed;      // m slot carries a word
  logic [MAX_M-1:0]             mIntern;    // handled without output
  logic [MAX_M-1:0]             mWait;      // waiting code
  logic [CODE_W-1:0]            mLimit;     // m digit limit
  logic [CODE_W-1:0]            bLimit;     // second aux digit limit

  // ***********************************************************
  // block classification
  // ***********************************************************
  always_comb begin
    // digit limits
    mLimit = afsh_pow10((cfgMDigits > MAX_DIGIT) ? MAX_DIGIT : cfgMDigits);
    bLimit = afsh_pow10((cfgBDigits > MAX_DIGIT) ? MAX_DIGIT : cfgBDigits);
    // no fault yet
    bad    = 1'b0;
    for (int i = 0; i < MAX_M; i++) begin
      // slot below the count
      mUsed[i]   = (2'(i) < blkMCount);
      // call, return and interrupt macro codes never leave the block
      mIntern[i] = (blkMCode[i] == M_SUB_CALL) || (blkMCode[i] == M_SUB_RET)
                || (blkMCode[i] == M_EXT_CALL) || (blkMCode[i] == M_INTR_ON)
                || (blkMCode[i] == M_INTR_OFF) || (blkMCode[i] == cfgSubCallCode)
                || (blkMCode[i] == cfgMacroCallCode)
                || (blkMCode[i] == cfgIntrOnCode)
                || (blkMCode[i] == cfgIntrOffCode);
      // waiting codes come from the configured range
      mWait[i]   = (blkMCode[i] >= cfgWaitLow) && (blkMCode[i] <= cfgWaitHigh);
      // too many digits
      if (mUsed[i] && (blkMCode[i] >= mLimit)) begin
        bad = 1'b1;
      end
    end
    // one m word unless three are allowed, never more than three
    if ((blkMCount > ONE_WORD) && !cfgMultiM) begin
      bad = 1'b1;
    end
    // three words at most
    if (blkMCount > MAX_M_CNT) begin
      bad = 1'b1;
    end
    // a waiting code stands alone among the m words of its block
    if ((blkMCount > ONE_WORD) && (|(mWait & mUsed))) begin
      bad = 1'b1;
    end
    // one second aux at most
    if (blkBCount > ONE_WORD) begin
      bad = 1'b1;
    end
    // letter must match
    if ((blkBCount == ONE_WORD) && (blkBLetter != cfgBLetter)) begin
      bad = 1'b1;
    end
    // second aux too long
    if ((blkBCount == ONE_WORD) && (blkBCode >= bLimit)) begin
      bad = 1'b1;
    end
    // s and t use the m limit
    if (blkSValid && (blkSCode >= mLimit)) begin
      bad = 1'b1;
    end
    if (blkTValid && (blkTCode >= mLimit)) begin
      bad = 1'b1;
    end
  end

  // a block waits for every channel to finish its previous command
  assign blkReady = (st_reg.state == ST_RUN) && !(|chanBusy);
  // bad blocks are consumed
  assign take     = blkValid && blkReady;

  // ***********************************************************
  // channel starts: lock and internal codes give no output
  // ***********************************************************
  always_comb begin
    // idle unless taken
    chanStart = '0;
    chanCode  = '0;
    for (int i = 0; i < MAX_M; i++) begin
      chanCode[i]  = blkMCode[i];
      // internal or waiting: no channel
      chanStart[i] = take && !bad && !auxLock && mUsed[i]
                   && !mIntern[i] && !mWait[i];
    end
    // s channel
    chanCode[CH_S]  = blkSCode;
    chanStart[CH_S] = take && !bad && !auxLock && blkSValid;
    // t channel
    chanCode[CH_T]  = blkTCode;
    chanStart[CH_T] = take && !bad && !auxLock && blkTValid;
    // second aux channel
    chanCode[CH_B]  = blkBCode;
    chanStart[CH_B] = take && !bad && !auxLock
                    && (blkBCount == ONE_WORD);
  end

  // ***********************************************************
  // sequencing, internal effects and waiting
  // ***********************************************************
  always_comb begin
    st_next          = st_reg;
    // pulses last one cycle
    st_next.progEnd  = 1'b0;
    st_next.progStop = 1'b0;
    st_next.optStop  = 1'b0;
    st_next.subCall  = 1'b0;
    st_next.subRet   = 1'b0;
    st_next.macCall  = 1'b0;
    st_next.intrOn   = 1'b0;
    st_next.intrOff  = 1'b0;
    st_next.alarm    = 1'b0;
    unique case (st_reg.state)
      ST_RUN: begin
        // taking blocks
        if (take && bad) begin
          // refused block: nothing leaves, the alarm pulses
          st_next.alarm = 1'b1;
        end else if (take) begin
          // effects below act whether or not the lock is on
          // each used slot
          for (int i = 0; i < MAX_M; i++) begin
            if (mUsed[i]) begin
              // program end
              if ((blkMCode[i] == M_END) || (blkMCode[i] == M_END_RW)) begin
                st_next.progEnd = 1'b1;
              end
              // stop
              if (blkMCode[i] == M_STOP) begin
                st_next.progStop = 1'b1;
              end
              // optional stop
              if (blkMCode[i] == M_OPT_STOP) begin
                st_next.optStop = 1'b1;
              end
              // call
              if ((blkMCode[i] == M_SUB_CALL) || (blkMCode[i] == M_EXT_CALL)
                  || (blkMCode[i] == cfgSubCallCode)) begin
                st_next.subCall = 1'b1;
              end
              // return
              if (blkMCode[i] == M_SUB_RET) begin
                st_next.subRet = 1'b1;
              end
              // macro call
              if (blkMCode[i] == cfgMacroCallCode) begin
                st_next.macCall = 1'b1;
              end
              // interrupt on
              if ((blkMCode[i] == M_INTR_ON) || (blkMCode[i] == cfgIntrOnCode)) begin
                st_next.intrOn = 1'b1;
              end
              // interrupt off
              if ((blkMCode[i] == M_INTR_OFF) || (blkMCode[i] == cfgIntrOffCode)) begin
                st_next.intrOff = 1'b1;
              end
            end
          end
          // a waiting code is shown to the peer, not to the machine
          if (mUsed[0] && mWait[0] && !mIntern[0] && !waitIgnore) begin
            st_next.state     = ST_SYNC;
            st_next.waitValid = 1'b1;
            st_next.waitCode  = blkMCode[0];
          end
        end
      end
      ST_SYNC: begin
        // release once the peer stands at the same code, or on ignore
        if (waitIgnore
            || (peerWaitValid && (peerWaitCode == st_reg.waitCode))) begin
          st_next.state     = ST_RUN;
          st_next.waitValid = 1'b0;
        end
      end
      // illegal code
      default: begin
        st_next.state     = ST_RUN;
        st_next.waitValid = 1'b0;
      end
    endcase
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // clear to idle
      st_reg       <= '0;
      st_reg.state <= ST_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  // ***********************************************************
  // one handshake channel per function
  // ***********************************************************
  generate
    for (genvar c = 0; c < NCHAN; c++) begin : gChan
      // one per function
      afsh_strobe_chan uChan (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .highSpeed (cfgHighSpeed),
        .start     (chanStart[c]),
        .startCode (chanCode[c]),
        .finConv   (finConv),
        .finHs     (finHs[c]),
        .codeOut   (auxCodeLines[c]),
        .strobeOut (auxStrobe[c]),
        .busy      (chanBusy[c])
      );
    end
  endgenerate

  // ***********************************************************
  // outputs
  // ***********************************************************
  // waiting handshake
  assign ownWaitValid = st_reg.waitValid;
  assign ownWaitCode  = st_reg.waitCode;
  // effect pulses
  assign progEnd      = st_reg.progEnd;
  assign progStop     = st_reg.progStop;
  assign optStop      = st_reg.optStop;
  assign subCall      = st_reg.subCall;
  assign subReturn    = st_reg.subRet;
  assign macroCall    = st_reg.macCall;
  assign intrMacroOn  = st_reg.intrOn;
  assign intrMacroOff = st_reg.intrOff;
  assign blkAlarm     = st_reg.alarm;

endmodule : afsh_aux_strobe

`default_nettype wire

//--- rtl/afsh_pkg.sv
package afsh_pkg;

  // ***********************************************************
  // widths and counts
  // ***********************************************************
  localparam int CODE_W = 32;   // width of one code word
  localparam int MAX_M  = 3;    // m words per block, at most
  localparam int NCHAN  = 6;    // m0, m1, m2, s, t, second aux
  localparam int CH_S   = 3;    // channel index of s
  localparam int CH_T   = 4;    // channel index of t
  localparam int CH_B   = 5;    // channel index of second aux

  localparam logic [1:0] ONE_WORD  = 2'h1;   // single word in a block
  localparam logic [1:0] MAX_M_CNT = 2'h3;   // three m words
  localparam logic [3:0] MAX_DIGIT = 4'h8;   // digit limit cap

  // ***********************************************************
  // m codes with a fixed meaning
  // ***********************************************************
  localparam logic [CODE_W-1:0] M_STOP     = 32'h0000_0000;  // program stop
  localparam logic [CODE_W-1:0] M_OPT_STOP = 32'h0000_0001;  // optional stop
  localparam logic [CODE_W-1:0] M_END      = 32'h0000_0002;  // end of program
  localparam logic [CODE_W-1:0] M_END_RW   = 32'h0000_001E;  // end and rewind
  localparam logic [CODE_W-1:0] M_INTR_ON  = 32'h0000_0060;  // interrupt macro on
  localparam logic [CODE_W-1:0] M_INTR_OFF = 32'h0000_0061;  // interrupt macro off
  localparam logic [CODE_W-1:0] M_SUB_CALL = 32'h0000_0062;  // subprogram call
  localparam logic [CODE_W-1:0] M_SUB_RET  = 32'h0000_0063;  // subprogram return
  localparam logic [CODE_W-1:0] M_EXT_CALL = 32'h0000_00C6;  // external sub call

  // ***********************************************************
  // address letter of the second auxiliary word
  // ***********************************************************
  typedef enum logic [2:0] {
    AFSH_LET_B = 3'h0,
    AFSH_LET_A = 3'h1,
    AFSH_LET_C = 3'h2,
    AFSH_LET_U = 3'h3,
    AFSH_LET_V = 3'h4,
    AFSH_LET_W = 3'h5
  } afsh_letter_type;

  // ***********************************************************
  // digit limit: smallest value that has too many digits
  // ***********************************************************
  function automatic logic [CODE_W-1:0] afsh_pow10(input logic [3:0] d);
    logic [CODE_W-1:0] r;
    unique case (d)
      4'h0:    r = 32'h0000_0001;
      4'h1:    r = 32'h0000_000A;
      4'h2:    r = 32'h0000_0064;
      4'h3:    r = 32'h0000_03E8;
      4'h4:    r = 32'h0000_2710;
      4'h5:    r = 32'h0001_86A0;
      4'h6:    r = 32'h000F_4240;
      4'h7:    r = 32'h0098_9680;
      default: r = 32'h05F5_E100;
    endcase
    return r;
  endfunction : afsh_pow10

endpackage : afsh_pkg

//--- rtl/afsh_strobe_chan.sv
`timescale 1ns/1ps
`default_nettype none

module afsh_strobe_chan (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // protocol select
  input  wire logic                        highSpeed,
  // command from the block decoder
  input  wire logic                        start,
  input  wire logic [afsh_pkg::CODE_W-1:0] startCode,
  // completion lines from the sequence controller
  input  wire logic                        finConv,
  input  wire logic                        finHs,
  // code and strobe toward the sequence controller, busy back to the block decoder
  output logic      [afsh_pkg::CODE_W-1:0] codeOut,
  output logic                             strobeOut,
  output logic                             busy
);
  import afsh_pkg::*;

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic [CODE_W-1:0] code;     // held code word
    logic              strobe;   // strobe level
    logic              armed;    // rise of finConv seen
    logic              finPrev;  // finConv one cycle ago
    logic              busy;     // waiting for completion
  } afsh_chan_type;

  afsh_chan_type st_reg;   // registered state
  afsh_chan_type st_next;  // next state

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    st_next         = st_reg;
    st_next.finPrev = finConv;
    if (start && !st_reg.busy) begin
      // code and strobe in the same edge; code then holds
      st_next.code  = startCode;
      st_next.busy  = 1'b1;
      st_next.armed = 1'b0;
      if (highSpeed) begin
        st_next.strobe = ~st_reg.strobe;
      end else begin
        st_next.strobe = 1'b1;
      end
    end else if (st_reg.busy && highSpeed) begin
      // done when the own completion line matches the strobe
      if (finHs == st_reg.strobe) begin
        st_next.busy = 1'b0;
      end
    end else if (st_reg.busy) begin
      // shared line: rise first, then the fall ends it
      if (finConv && !st_reg.finPrev) begin
        st_next.armed = 1'b1;
      end else if (st_reg.armed && !finConv) begin
        st_next.armed  = 1'b0;
        st_next.strobe = 1'b0;
        st_next.busy   = 1'b0;
      end
    end
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign codeOut   = st_reg.code;
  assign strobeOut = st_reg.strobe;
  assign busy      = st_reg.busy;

endmodule : afsh_strobe_chan

`default_nettype wire
